/* iocfg_params.svh */
// constants of the i/o pin configuration block: offsets, field codes, reset values
// assumes an apb slave window of 256 bytes with 32-bit aligned registers
`ifndef IOCFG_PARAMS_SVH
`define IOCFG_PARAMS_SVH

`define IOCFG_NPORT 2
`define IOCFG_NPIN 8
`define IOCFG_NPAIR 4

// per-port register offsets, port n sits at n * 0x40
`define IOCFG_OFS_DATA 6'h00
`define IOCFG_OFS_DMODE 6'h04
`define IOCFG_OFS_REGOUT 6'h08
`define IOCFG_OFS_HYST 6'h0c
`define IOCFG_OFS_INTMODE 6'h10
`define IOCFG_OFS_THRESH 6'h14
`define IOCFG_OFS_RSTCFG 6'h18
`define IOCFG_OFS_INTSTAT 6'h1c
`define IOCFG_OFS_INTCLR 6'h20
`define IOCFG_OFS_INTEN 6'h24
`define IOCFG_OFS_PINSTATE 6'h28
`define IOCFG_ADDR_GLOBAL 8'h80

// three-bit drive modes
`define IOCFG_DM_HIZ_ANALOG 3'h0
`define IOCFG_DM_HIZ_DIGITAL 3'h1
`define IOCFG_DM_RES_UP 3'h2
`define IOCFG_DM_RES_DN 3'h3
`define IOCFG_DM_OD_LO 3'h4
`define IOCFG_DM_OD_HI 3'h5
`define IOCFG_DM_STRONG 3'h6
`define IOCFG_DM_RES_UPDN 3'h7

// port reset configuration codes
`define IOCFG_RST_HIZ 2'h0
`define IOCFG_RST_PULLUP 2'h1
`define IOCFG_RST_PULLDN 2'h2

// interrupt detect modes
`define IOCFG_INT_NONE 2'h0
`define IOCFG_INT_RISE 2'h1
`define IOCFG_INT_FALL 2'h2
`define IOCFG_INT_BOTH 2'h3

// pair threshold codes
`define IOCFG_VTH_HALF_IO 2'h0
`define IOCFG_VTH_04_IO 2'h1
`define IOCFG_VTH_HALF_REF 2'h2
`define IOCFG_VTH_FULL_REF 2'h3

// nonvolatile reset configuration contents per port
`define IOCFG_NV_RSTCFG0 2'h1
`define IOCFG_NV_RSTCFG1 2'h0

`endif

/* iocfg_pkg.sv */
// types shared by the i/o pin configuration block
// assumes iocfg_params.svh for the numeric constants
package iocfg_pkg;
	typedef enum logic [1:0] {LD_READ, LD_STORE, LD_DONE} iocfg_ld_e;
	typedef logic [2:0] iocfg_dm_t;
endpackage

/* iocfg_edge.sv */
// edge detector for a group of pins, one two-bit mode per pin
// assumes sig is synchronous to pclk
`timescale 1ns/1ns
`include "iocfg_params.svh"
module iocfg_edge #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] sig,
	input wire logic [2*W-1:0] mode,
	output logic [W-1:0] evt
);
	logic [W-1:0] prev_ff;
	logic armed_ff;

	// history of the pins; the first cycle only primes it so no false edge follows reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_ff <= '0;
			armed_ff <= 1'b0;
		end
		else
		begin
			prev_ff <= sig;
			armed_ff <= 1'b1;
		end
	end

	// per-pin selection of rising, falling, both or none
	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			unique case (mode[2*i +: 2])
				`IOCFG_INT_NONE: evt[i] = 1'b0;
				`IOCFG_INT_RISE: evt[i] = armed_ff & sig[i] & ~prev_ff[i];
				`IOCFG_INT_FALL: evt[i] = armed_ff & ~sig[i] & prev_ff[i];
				`IOCFG_INT_BOTH: evt[i] = armed_ff & (sig[i] ^ prev_ff[i]);
			endcase
		end
	end
endmodule

/* iocfg_nvrom.sv */
// nonvolatile store of per-port reset configuration, registered read
// assumes addr is below the port count
`timescale 1ns/1ns
`include "iocfg_params.svh"
module iocfg_nvrom (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic addr,
	output logic [1:0] rd_data_ff
);
	// contents are fixed by IOCFG_NV_RSTCFG0 and IOCFG_NV_RSTCFG1, written at production time
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_data_ff <= 2'h0;
		else
			rd_data_ff <= addr ? `IOCFG_NV_RSTCFG1 : `IOCFG_NV_RSTCFG0;
	end
endmodule

/* iocfg_top.sv */
// i/o pin configuration for two special-pin ports with apb register access
// assumes synchronous pad inputs, pclk at 50 MHz, lp_mode from the power controller
// Overview of operation
// RULE1: all pins held high impedance analog while reset is asserted
// RULE2: after reset each port may be set to pull-up or pull-down alone
// RULE3: reset release copies nonvolatile port reset config into registers automatically
// RULE4: pins keep their state in low-power modes until woken or reset
// RULE5: port interrupt detection keeps running in low-power modes to wake part
// RULE6: each special pin selects supply-level or regulated high output
// RULE7: resistive pull modes unavailable on pins with regulated output
// RULE8: pins paired, each pair shares one reference so one threshold
// RULE9: pair threshold choices: half supply, 0.4 supply, half ref, full ref
// RULE10: inputs default to standard thresholds, differential only when selected
// RULE11: pair reference may take the analog global line, acting as comparator
// RULE12: per-pin hysteresis enable for the input buffer
// RULE13: software keeps overdriven pins in modes 0, 1 or 4
// RULE14: drive mode 4, open drain low, is encoded 1,0,0
// RULE15: per-pin rising, falling, both or no interrupt; event sets status bit
// RULE16: pull mode written under regulated output falls back to non-resistive drive
`timescale 1ns/1ns
`include "iocfg_params.svh"
module iocfg_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lp_mode,
	input wire logic [15:0] pin_in,
	output logic [15:0] pad_dr_ff,
	output logic [47:0] pad_dm_ff,
	output logic [15:0] pad_inbuf_en_ff,
	output logic [15:0] pad_regout_ff,
	output logic [15:0] pad_hyst_ff,
	output logic [15:0] pad_vth_sel_ff,
	output logic [7:0] pad_diff_en_ff,
	output logic [7:0] pad_vref_aglobal_ff,
	output logic cfg_ready,
	output logic irq
);
	localparam int NP = `IOCFG_NPORT;
	localparam int NPIN = `IOCFG_NPIN;

	logic [NP-1:0][7:0] dr_ff;
	logic [NP-1:0][23:0] dm_ff;
	logic [NP-1:0][7:0] regout_ff;
	logic [NP-1:0][7:0] hyst_ff;
	logic [NP-1:0][15:0] intmode_ff;
	logic [NP-1:0][15:0] thresh_ff;
	logic [NP-1:0][1:0] rstcfg_ff;
	logic [NP-1:0][7:0] intstat_ff;
	logic [NP-1:0][7:0] inten_ff;
	logic [NP-1:0][7:0] evt;
	logic [NP-1:0][23:0] eff_dm;
	iocfg_pkg::iocfg_ld_e ld_state_ff;
	logic ld_idx_ff;
	logic [1:0] nv_data;
	logic wr_en;
	logic rd_en;
	logic port_sel;
	logic [5:0] ofs;
	logic is_global;
	logic mapped;
	logic ld_apply;
	logic sw_apply;
	logic apply_port;
	logic [1:0] apply_cfg;
	logic [31:0] nxt_rdata;
	logic [31:0] rdata_ff;

	// zero wait state slave
	assign pready = 1'b1;
	assign port_sel = paddr[6];
	assign ofs = paddr[5:0];
	assign is_global = (paddr == `IOCFG_ADDR_GLOBAL);
	assign wr_en = psel & penable & pwrite & mapped;
	assign rd_en = psel & ~penable & ~pwrite; // setup phase, data stands in access
	assign pslverr = psel & penable & ~mapped;
	assign cfg_ready = (ld_state_ff == iocfg_pkg::LD_DONE);

	// address decode; status and pin state are read-only, clear is write-only
	always_comb
	begin
		if (is_global)
			mapped = ~pwrite;
		else if (paddr[7])
			mapped = 1'b0;
		else
		begin
			unique case (ofs)
				`IOCFG_OFS_DATA, `IOCFG_OFS_DMODE, `IOCFG_OFS_REGOUT, `IOCFG_OFS_HYST,
				`IOCFG_OFS_INTMODE, `IOCFG_OFS_THRESH, `IOCFG_OFS_RSTCFG,
				`IOCFG_OFS_INTEN: mapped = 1'b1;
				`IOCFG_OFS_INTSTAT, `IOCFG_OFS_PINSTATE: mapped = ~pwrite;
				`IOCFG_OFS_INTCLR: mapped = pwrite;
				default: mapped = 1'b0;
			endcase
		end
	end

	// nonvolatile reset data store
	iocfg_nvrom u_nvrom (
		.pclk(pclk),
		.presetn(presetn),
		.addr(ld_idx_ff),
		.rd_data_ff(nv_data)
	);

	// loader walks the ports once after reset release, no software involved
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ld_state_ff <= iocfg_pkg::LD_READ;
			ld_idx_ff <= 1'b0;
		end
		else
		begin
			unique case (ld_state_ff)
				iocfg_pkg::LD_READ: ld_state_ff <= iocfg_pkg::LD_STORE; // [RULE3]
				iocfg_pkg::LD_STORE:
				begin
					ld_idx_ff <= ~ld_idx_ff;
					ld_state_ff <= ld_idx_ff ? iocfg_pkg::LD_DONE : iocfg_pkg::LD_READ;
				end
				iocfg_pkg::LD_DONE: ld_state_ff <= iocfg_pkg::LD_DONE;
			endcase
		end
	end

	// a port reset config arrives either from the loader or from software
	assign ld_apply = (ld_state_ff == iocfg_pkg::LD_STORE); // [RULE3]
	assign sw_apply = wr_en & ~is_global & (ofs == `IOCFG_OFS_RSTCFG); // [RULE2]
	assign apply_port = ld_apply ? ld_idx_ff : port_sel;
	assign apply_cfg = ld_apply ? nv_data : pwdata[1:0];

	// configuration registers; applying a reset config rewrites one port only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dr_ff <= '0;
			dm_ff <= '0; // [RULE1]
			regout_ff <= '0;
			hyst_ff <= '0;
			intmode_ff <= '0;
			thresh_ff <= '0; // [RULE10]
			rstcfg_ff <= '0;
			inten_ff <= '0;
		end
		else
		begin
			if (ld_apply | sw_apply)
			begin
				rstcfg_ff[apply_port] <= apply_cfg; // [RULE2]
				unique case (apply_cfg)
					`IOCFG_RST_PULLUP:
					begin
						dm_ff[apply_port] <= {NPIN{`IOCFG_DM_RES_UP}};
						dr_ff[apply_port] <= 8'hff;
					end
					`IOCFG_RST_PULLDN:
					begin
						dm_ff[apply_port] <= {NPIN{`IOCFG_DM_RES_DN}};
						dr_ff[apply_port] <= 8'h00;
					end
					default:
					begin
						dm_ff[apply_port] <= {NPIN{`IOCFG_DM_HIZ_ANALOG}};
						dr_ff[apply_port] <= 8'h00;
					end
				endcase
			end
			if (wr_en & ~is_global & ~ld_apply)
			begin
				unique case (ofs)
					`IOCFG_OFS_DATA: dr_ff[port_sel] <= pwdata[7:0];
					`IOCFG_OFS_DMODE: dm_ff[port_sel] <= pwdata[23:0];
					`IOCFG_OFS_REGOUT: regout_ff[port_sel] <= pwdata[7:0]; // [RULE6]
					`IOCFG_OFS_HYST: hyst_ff[port_sel] <= pwdata[7:0]; // [RULE12]
					`IOCFG_OFS_INTMODE: intmode_ff[port_sel] <= pwdata[15:0]; // [RULE15]
					`IOCFG_OFS_THRESH: thresh_ff[port_sel] <= pwdata[15:0]; // [RULE9] [RULE11]
					`IOCFG_OFS_INTEN: inten_ff[port_sel] <= pwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// edge detection keeps running whatever lp_mode says, so a pin can wake the part
	generate
		for (genvar p = 0; p < NP; p++)
		begin : g_edge
			iocfg_edge #(.W(NPIN)) u_edge (
				.pclk(pclk),
				.presetn(presetn),
				.sig(pin_in[p*NPIN +: NPIN] & pad_inbuf_en_ff[p*NPIN +: NPIN]),
				.mode(intmode_ff[p]),
				.evt(evt[p])
			); // [RULE5]
		end
	endgenerate

	// sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			intstat_ff <= '0;
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				if (wr_en & ~is_global & (ofs == `IOCFG_OFS_INTCLR) & (port_sel == p[0]))
					intstat_ff[p] <= (intstat_ff[p] & ~pwdata[7:0]) | evt[p]; // [RULE15]
				else
					intstat_ff[p] <= intstat_ff[p] | evt[p]; // [RULE15]
			end
		end
	end

	// level interrupt while any enabled status bit is set
	assign irq = |(intstat_ff & inten_ff); // [RULE5]

	// pull modes are replaced by digital high z or strong drive under regulated output
	always_comb
	begin
		for (int p = 0; p < NP; p++)
		begin
			for (int i = 0; i < NPIN; i++)
			begin
				eff_dm[p][3*i +: 3] = dm_ff[p][3*i +: 3];
				if (regout_ff[p][i])
				begin
					unique case (dm_ff[p][3*i +: 3])
						`IOCFG_DM_RES_UP, `IOCFG_DM_RES_DN:
							eff_dm[p][3*i +: 3] = `IOCFG_DM_STRONG; // [RULE7] [RULE16]
						`IOCFG_DM_RES_UPDN:
							eff_dm[p][3*i +: 3] = `IOCFG_DM_HIZ_DIGITAL; // [RULE7] [RULE16]
						default: ;
					endcase
				end
			end
		end
	end

	// pad drive; held high z analog until the loader is done, frozen during low power
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_dr_ff <= '0;
			pad_dm_ff <= '0; // [RULE1]
			pad_inbuf_en_ff <= '0;
			pad_regout_ff <= '0;
			pad_hyst_ff <= '0;
		end
		else if (!cfg_ready)
		begin
			pad_dm_ff <= '0; // [RULE1]
			pad_inbuf_en_ff <= '0;
		end
		else if (!lp_mode) // [RULE4]
		begin
			pad_dr_ff <= dr_ff;
			pad_dm_ff <= eff_dm; // [RULE14]
			pad_regout_ff <= regout_ff; // [RULE6]
			pad_hyst_ff <= hyst_ff; // [RULE12]
			for (int p = 0; p < NP; p++)
				for (int i = 0; i < NPIN; i++)
					pad_inbuf_en_ff[p*NPIN+i] <= (eff_dm[p][3*i +: 3] != `IOCFG_DM_HIZ_ANALOG);
		end
	end

	// one threshold setting per pair drives both pins of the pair
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_vth_sel_ff <= '0;
			pad_diff_en_ff <= '0; // [RULE10]
			pad_vref_aglobal_ff <= '0;
		end
		else if (cfg_ready & ~lp_mode) // [RULE4]
		begin
			for (int p = 0; p < NP; p++)
			begin
				pad_vth_sel_ff[p*8 +: 8] <= thresh_ff[p][7:0]; // [RULE8] [RULE9]
				pad_diff_en_ff[p*4 +: 4] <= thresh_ff[p][11:8]; // [RULE10]
				pad_vref_aglobal_ff[p*4 +: 4] <= thresh_ff[p][15:12]; // [RULE11]
			end
		end
	end

	// read mux; unmapped and write-only locations read zero
	always_comb
	begin
		nxt_rdata = 32'h0;
		if (rd_en & is_global)
			nxt_rdata = {31'h0, cfg_ready};
		else if (rd_en & mapped)
		begin
			unique case (ofs)
				`IOCFG_OFS_DATA: nxt_rdata = {24'h0, dr_ff[port_sel]};
				`IOCFG_OFS_DMODE: nxt_rdata = {8'h0, dm_ff[port_sel]};
				`IOCFG_OFS_REGOUT: nxt_rdata = {24'h0, regout_ff[port_sel]};
				`IOCFG_OFS_HYST: nxt_rdata = {24'h0, hyst_ff[port_sel]};
				`IOCFG_OFS_INTMODE: nxt_rdata = {16'h0, intmode_ff[port_sel]};
				`IOCFG_OFS_THRESH: nxt_rdata = {16'h0, thresh_ff[port_sel]};
				`IOCFG_OFS_RSTCFG: nxt_rdata = {30'h0, rstcfg_ff[port_sel]};
				`IOCFG_OFS_INTSTAT: nxt_rdata = {24'h0, intstat_ff[port_sel]};
				`IOCFG_OFS_INTEN: nxt_rdata = {24'h0, inten_ff[port_sel]};
				`IOCFG_OFS_PINSTATE: nxt_rdata = {24'h0, pin_in[port_sel*NPIN +: NPIN]};
				default: nxt_rdata = 32'h0;
			endcase
		end
	end

	// read data registered at setup, so it stands through the zero-wait access and is zero after
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_ff <= 32'h0;
		else
			rdata_ff <= nxt_rdata;
	end
	assign prdata = rdata_ff;
endmodule

/* iocfg_checker.sv */
// concurrent checks on the ports of the pin configuration top
// assumes one pclk domain and presetn asynchronous, active low
`timescale 1ns/1ns
module iocfg_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic lp_mode,
	input wire logic [15:0] pad_dr_ff,
	input wire logic [47:0] pad_dm_ff,
	input wire logic [15:0] pad_inbuf_en_ff,
	input wire logic [15:0] pad_regout_ff,
	input wire logic [15:0] pad_hyst_ff,
	input wire logic [15:0] pad_vth_sel_ff,
	input wire logic [7:0] pad_diff_en_ff,
	input wire logic [7:0] pad_vref_aglobal_ff,
	input wire logic cfg_ready
);
	logic [15:0] inbuf_exp;
	logic [15:0] pull_bad;
	// per-pin view of the drive field, pull modes are illegal under regulated output
	always_comb
	begin
		for (int i = 0; i < 16; i++)
		begin
			inbuf_exp[i] = pad_dm_ff[3*i+:3] != 3'h0;
			pull_bad[i] = pad_regout_ff[i] && (pad_dm_ff[3*i+:3] inside {3'h2, 3'h3, 3'h7});
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// reset itself is the cause here, so no disable
	rst_hiz_a: assert property (disable iff (1'b0) !presetn |-> pad_dm_ff == 48'h0 && !cfg_ready)
		else $error("pads not analog hiz in reset");
	load_seq_a: assert property (($rose(presetn) && !lp_mode) |-> (!cfg_ready && pad_dm_ff == 48'h0 && pad_diff_en_ff == 8'h0)[*4] ##1 (cfg_ready && pad_dm_ff == 48'h0) ##1 pad_dm_ff == {24'h0, {8{3'h2}}})
		else $error("reset config load sequence wrong");
	inbuf_mode_a: assert property (pad_inbuf_en_ff == inbuf_exp)
		else $error("input buffer enable disagrees with mode");
	no_pull_a: assert property (pull_bad == 16'h0)
		else $error("resistive mode with regulated output");
	lp_hold_a: assert property (($past(lp_mode) && $past(presetn)) |-> $stable(pad_dm_ff) && $stable(pad_dr_ff) && $stable(pad_vth_sel_ff))
		else $error("pad state moved in low power");
	dm_pass_a: assert property ((psel && penable && pwrite && paddr == 8'h04 && !lp_mode && (pwdata[2:0] inside {3'h0, 3'h1, 3'h4, 3'h5, 3'h6})) ##1 !lp_mode |=> pad_dm_ff[2:0] == $past(pwdata[2:0], 2))
		else $error("drive mode not passed to pad");
	thr_cfg_a: assert property ((psel && penable && pwrite && paddr == 8'h54 && !lp_mode) ##1 !lp_mode |=> {pad_vref_aglobal_ff[7:4], pad_diff_en_ff[7:4], pad_vth_sel_ff[15:8]} == $past(pwdata[15:0], 2))
		else $error("pair threshold setting not applied");
	hyst_cfg_a: assert property ((psel && penable && pwrite && paddr == 8'h4c && !lp_mode) ##1 !lp_mode |=> pad_hyst_ff[15:8] == $past(pwdata[7:0], 2))
		else $error("hysteresis enable not applied");
	bad_addr_a: assert property ((psel && penable && paddr == 8'hfc) |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule

bind iocfg_top iocfg_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pslverr, .lp_mode, .pad_dr_ff, .pad_dm_ff, .pad_inbuf_en_ff, .pad_regout_ff,
	.pad_hyst_ff, .pad_vth_sel_ff, .pad_diff_en_ff, .pad_vref_aglobal_ff, .cfg_ready);

/* tb_iocfg_top.sv */
// self-checking bench for the pin configuration top over apb
// assumes the checker is bound from its own file
`timescale 1ns/1ns
`include "iocfg_params.svh"
module tb_iocfg_top;
	// reset starts high so the first drop is a real edge for the async reset
	logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lp_mode = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, v;
	logic [15:0] pin_in = 16'h0, pad_dr_ff, pad_inbuf_en_ff, pad_regout_ff, pad_hyst_ff;
	logic [15:0] pad_vth_sel_ff;
	logic [47:0] pad_dm_ff;
	logic [7:0] pad_diff_en_ff, pad_vref_aglobal_ff;
	logic pready, pslverr, cfg_ready, irq;
	logic [32:0] exp_q[$];
	int fails = 0, total_checks = 0, cyc = 0, seed = 32'h366c;
	always #10 pclk = ~pclk;
	iocfg_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .lp_mode, .pin_in, .pad_dr_ff, .pad_dm_ff, .pad_inbuf_en_ff,
		.pad_regout_ff, .pad_hyst_ff, .pad_vth_sel_ff, .pad_diff_en_ff, .pad_vref_aglobal_ff,
		.cfg_ready, .irq);
	task chk(input string n, input logic [47:0] s, input logic [47:0] e);
		total_checks++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard, the run needs well under a thousand cycles
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			end_sim();
		end
	end
	// every completed access is matched against the oldest note
	always @(posedge pclk)
		if (psel && penable && pready)
			chk("apb", {pslverr, prdata}, exp_q.pop_front());
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	// reset, then wait for the stored port config to land
	task do_reset();
		presetn <= 1'b0;
		tick(10);
		chk("rst", {pad_dm_ff[46:0], cfg_ready}, 48'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 20 && cfg_ready !== 1'b1; i++)
			@(posedge pclk);
		tick(2);
		chk("ld dm", pad_dm_ff, {24'h0, {8{`IOCFG_DM_RES_UP}}});
		chk("ld dr", pad_dr_ff, 48'hff);
		apb(1'b0, 8'h80, 32'h0, 33'h1);
		apb(1'b0, 8'h18, 32'h0, 33'h1);
		apb(1'b0, 8'h58, 32'h0, 33'h0);
		$display("test reset done");
	endtask
	initial
	begin
		do_reset();
		wr(8'h58, 32'h2);
		tick(1);
		chk("port", pad_dm_ff, {{8{`IOCFG_DM_RES_DN}}, {8{`IOCFG_DM_RES_UP}}});
		// pin0 regulated, pin1 plain: every mode through both
		wr(8'h08, 32'h1);
		for (int m = 0; m < 8; m++)
		begin
			wr(8'h04, {8'h0, {8{m[2:0]}}});
			tick(1);
			chk("dm", pad_dm_ff[5:0], {m[2:0], (m == 7) ? 3'h1 : (m == 2 || m == 3) ? 3'h6 : m[2:0]});
			chk("reg", pad_regout_ff, 48'h1);
		end
		$display("test modes done");
		// interrupts in low power while pads stay frozen
		wr(8'h08, 32'h0);
		wr(8'h04, {8'h0, {8{`IOCFG_DM_HIZ_DIGITAL}}});
		wr(8'h10, 32'h39);
		wr(8'h20, 32'hff);
		wr(8'h24, 32'hf);
		@(posedge pclk);
		lp_mode <= 1'b1;
		wr(8'h04, 32'h0);
		@(posedge pclk);
		pin_in <= 16'h000f;
		tick(2);
		chk("irq", irq, 48'h1);
		chk("lp", pad_dm_ff[2:0], 48'h1);
		apb(1'b0, 8'h1c, 32'h0, 33'h5);
		@(posedge pclk);
		pin_in <= 16'h0;
		tick(2);
		apb(1'b0, 8'h1c, 32'h0, 33'h7);
		wr(8'h24, 32'h0);
		tick(1);
		chk("mask", irq, 48'h0);
		wr(8'h24, 32'hf);
		wr(8'h20, 32'h5);
		apb(1'b0, 8'h1c, 32'h0, 33'h2);
		@(posedge pclk);
		lp_mode <= 1'b0;
		tick(2);
		chk("wake", {pad_dm_ff[2:0], irq}, 48'h1);
		wr(8'h20, 32'hff);
		tick(1);
		chk("clr", irq, 48'h0);
		$display("test irq done");
		// random pair thresholds, hysteresis and pad levels; driven pins kept open drain low on port 1, high z analog on port 0
		v = $random(seed);
		wr(8'h44, {8'h0, {8{`IOCFG_DM_OD_LO}}});
		@(posedge pclk);
		pin_in <= v[31:16];
		wr(8'h54, v);
		wr(8'h4c, v);
		tick(1);
		chk("thr", {pad_vref_aglobal_ff[7:4], pad_diff_en_ff[7:4], pad_vth_sel_ff[15:8]}, v[15:0]);
		chk("hys", pad_hyst_ff[15:8], v[7:0]);
		chk("od", pad_dm_ff[47:24], {8{`IOCFG_DM_OD_LO}});
		apb(1'b0, 8'h54, 32'h0, {17'h0, v[15:0]});
		apb(1'b0, 8'h68, 32'h0, {25'h0, v[31:24]});
		apb(1'b0, 8'hfc, 32'h0, 33'h100000000);
		apb(1'b1, 8'h1c, 32'hff, 33'h100000000);
		apb(1'b0, 8'h20, 32'h0, 33'h100000000);
		$display("test config done");
		do_reset();
		end_sim();
	end
endmodule
